//--- rtl/utxdb_tx.sv
// Transmit side of the serial port with optional double buffering
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module utxdb_tx
  import utxdb_pkg::*;
#(
  parameter int BIT_DIV = utxdb_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  // Classic Wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [3:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK,
  // Interrupt
  output logic             IRQ,
  // Serial line
  utxdb_if.tx              LINE
);
  import utxdb_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_SHIFT = 3'b010,
    S_STOP  = 3'b100
  } utxdb_state_e;

  // ****************************************
  // Registers
  // ****************************************
  utxdb_state_e state_q;
  logic [7:0]  ctrl_q, mask_q, st_q, hold_q;
  logic        hold_tb9_q, hold_full_q;
  logic [9:0]  shift_q;
  logic [3:0]  bits_left_q;
  logic [15:0] baud_q;
  logic        txd_q, ack_q, irq_q;
  logic [31:0] rdat_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire req      = WB_CYC && WB_STB && !ack_q;
  wire wr_lane0 = req && WB_WE && WB_SEL[0];
  wire wr_ctrl  = wr_lane0 && WB_ADR == ADDR_CTRL;
  wire wr_data  = wr_lane0 && WB_ADR == ADDR_DATA;
  wire wr_mask  = wr_lane0 && WB_ADR == ADDR_MASK;
  wire rd_stat  = req && !WB_WE && WB_ADR == ADDR_STATUS;
  wire dbe      = ctrl_q[CTRL_DBE_BIT];
  wire [1:0] mode = ctrl_q[CTRL_MODE_LSB +: 2];
  wire nine     = mode[1];
  wire tick     = baud_q == 16'(BIT_DIV - 1);
  wire idle     = state_q == S_IDLE;
  wire stop_end = state_q == S_STOP && tick;
  // Next frame may start from idle or right at the end of a stop bit
  // Unbuffered waits for idle, so a pending byte is never dropped at stop
  wire can_load = idle || (dbe && stop_end);
  wire start_now = hold_full_q && can_load;
  // ninth bit sampled with the data in buffered mode
  wire load_tb9 = dbe ? hold_tb9_q : ctrl_q[CTRL_TB9_BIT];
  // unbuffered flag when last data/ninth bit leaves
  wire data_done = state_q == S_SHIFT && tick && bits_left_q == 4'h0;
  wire txi_set  = dbe ? start_now : data_done;
  wire live_b9  = !dbe && nine && bits_left_q == 4'h1;
  wire [7:0] st_live = {5'h00, hold_full_q, !idle, 1'b0};
  wire [7:0] st_rd   = st_q | st_live;

  wire [31:0] rmux =
    WB_ADR == ADDR_CTRL   ? {24'h000000, ctrl_q} :
    WB_ADR == ADDR_STATUS ? {24'h000000, st_rd}  :
    WB_ADR == ADDR_MASK   ? {24'h000000, mask_q} : 32'h00000000;

  // ****************************************
  // Bus slave: one-cycle ack
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rmux : 32'h00000000;
      if (wr_ctrl) ctrl_q <= WB_DAT_I[7:0];
      if (wr_mask) mask_q <= WB_DAT_I[7:0];
    end
  end

  // Sticky flag: set wins over read-clear
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q  <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      st_q[ST_TXI_BIT] <= txi_set || (st_q[ST_TXI_BIT] && !rd_stat);
      irq_q <= (st_q[ST_TXI_BIT] && mask_q[ST_TXI_BIT]) ||
               (txi_set && mask_q[ST_TXI_BIT]);
    end
  end

  // ****************************************
  // Holding stage
  // ****************************************
  // write accepted while shifter busy
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hold_q      <= 8'h00;
      hold_tb9_q  <= 1'b0;
      hold_full_q <= 1'b0;
    end else if (wr_data) begin
      hold_q      <= WB_DAT_I[7:0];
      hold_tb9_q  <= ctrl_q[CTRL_TB9_BIT];
      hold_full_q <= 1'b1;
    end else if (start_now) begin
      hold_full_q <= 1'b0;
    end
  end
  // Unbuffered: a write while busy is held until the shifter is idle, and a second write overwrites it; software
  // must wait for the interrupt, as in a single-buffered port.

  // ****************************************
  // Shifter
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q     <= S_IDLE;
      shift_q     <= 10'h3FF;
      bits_left_q <= 4'h0;
      baud_q      <= 16'h0000;
      txd_q       <= 1'b1;
    end else begin
      baud_q <= (idle || tick) ? 16'h0000 : baud_q + 16'h0001;
      unique case (state_q)
        S_IDLE, S_STOP: begin
          if (start_now) begin
            // start bit follows the single stop bit
            // start, eight data bits LSB first
            // ninth bit appended in modes 2 and 3
            shift_q     <= {1'b1, load_tb9, hold_q};
            bits_left_q <= nine ? 4'h9 : 4'h8;
            txd_q       <= 1'b0;
            state_q     <= S_SHIFT;
          end else if (stop_end) begin
            state_q <= S_IDLE;
          end
        end
        S_SHIFT: begin
          if (tick) begin
            txd_q   <= live_b9 ? ctrl_q[CTRL_TB9_BIT] : shift_q[0];
            shift_q <= {1'b1, shift_q[9:1]};
            bits_left_q <= bits_left_q - 4'h1;
            if (bits_left_q == 4'h0) begin
              txd_q   <= 1'b1;
              state_q <= S_STOP;
            end
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign WB_ACK   = ack_q;
  assign WB_DAT_O = rdat_q;
  assign IRQ      = irq_q;
  assign LINE.txd = txd_q;
endmodule

//--- common/utxdb_pkg.sv
// Shared constants for the double-buffered serial transmitter
package utxdb_pkg;

  // ****************************************
  // Register map (word aligned, classic Wishbone)
  // ****************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam logic [3:0] ADDR_MASK   = 4'hC;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TB9_BIT  = 2;
  localparam int CTRL_DBE_BIT  = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status / mask fields
  localparam int ST_TXI_BIT  = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Frame lengths
  localparam int BITS_MODE1 = 10;
  localparam int BITS_MODE23 = 11;

  // Baud divider default, in clock cycles per bit
  localparam int BIT_CYCLES = 16;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_8BIT  = 2'h1,
    MODE_9BIT  = 2'h2,
    MODE_9VAR  = 2'h3
  } utxdb_mode_e;

endpackage

//--- common/utxdb_if.sv
// Serial line between the transmitter and the remote receiver
`timescale 1ns/1ns
interface utxdb_if;
  logic txd;
  modport tx (output txd);
  modport rx (input  txd);
endinterface

//--- rtl/utxdb_rx.sv
// Remote receiver end of the serial line
`timescale 1ns/1ns
module utxdb_rx
  import utxdb_pkg::*;
#(
  parameter int BIT_DIV = utxdb_pkg::BIT_CYCLES
) (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  // Frame format
  input  wire logic       NINE_BITS,
  // Received character
  output logic      [7:0] RX_DATA,
  output logic            RX_BIT9,
  output logic            RX_VALID,
  output logic            RX_FRAME_ERR,
  // Serial line
  utxdb_if.rx             LINE
);
  import utxdb_pkg::*;

  logic [15:0] cnt_q;
  logic [3:0]  idx_q;
  logic        busy_q;
  logic [8:0]  sh_q;
  logic [7:0]  data_q;
  logic        b9_q, vld_q, ferr_q;

  wire mid  = cnt_q == 16'(BIT_DIV - 1);
  wire [3:0] last = NINE_BITS ? 4'hA : 4'h9;

  // ****************************************
  // Sample each bit at its centre
  // ****************************************
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cnt_q <= 16'h0000; idx_q <= 4'h0; busy_q <= 1'b0;
      sh_q <= 9'h000; data_q <= 8'h00; b9_q <= 1'b0;
      vld_q <= 1'b0; ferr_q <= 1'b0;
    end else begin
      vld_q <= 1'b0;
      if (!busy_q) begin
        if (!LINE.txd) begin
          busy_q <= 1'b1;
          cnt_q  <= 16'(BIT_DIV / 2);
          idx_q  <= 4'h0;
        end
      end else begin
        cnt_q <= mid ? 16'h0000 : cnt_q + 16'h0001;
        if (mid) begin
          idx_q <= idx_q + 4'h1;
          if (idx_q == last) begin
            busy_q <= 1'b0;
            data_q <= sh_q[7:0];
            b9_q   <= NINE_BITS ? sh_q[8] : 1'b0;
            ferr_q <= !LINE.txd;
            vld_q  <= 1'b1;
          end else if (idx_q != 4'h0) begin
            sh_q <= NINE_BITS ? {LINE.txd, sh_q[8:1]}
                              : {1'b0, LINE.txd, sh_q[7:1]};
          end
        end
      end
    end
  end

  assign RX_DATA      = data_q;
  assign RX_BIT9      = b9_q;
  assign RX_VALID     = vld_q;
  assign RX_FRAME_ERR = ferr_q;
endmodule

//--- bench/utxdb_monitor.sv
// Line checker for frame timing on the serial transmit wire
`timescale 1ns/1ns
module utxdb_monitor #(
  parameter int BIT_DIV = 4
) (
  // Clock, reset and line
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic txd
);
  // ****************************************
  // Low run counter and assertions
  // ****************************************
  int lo_q;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) lo_q <= 0;
    else lo_q <= txd ? 0 : lo_q + 1;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_start; $fell(txd) |-> !txd[*4]; endproperty
  a_start: assert property (p_start) else $error("start bit short");
  property p_hold; $changed(txd) |=> $stable(txd)[*3]; endproperty
  a_hold: assert property (p_hold) else $error("bit cut short");
  property p_stop; $rose(txd) |-> txd[*4]; endproperty
  a_stop: assert property (p_stop) else $error("high bit short");
  property p_lowmul; $rose(txd) |-> lo_q % BIT_DIV == 0; endproperty
  a_lowmul: assert property (p_lowmul) else $error("off grid");
  property p_lowmin; $rose(txd) |-> lo_q >= BIT_DIV; endproperty
  a_lowmin: assert property (p_lowmin) else $error("low run short");
  property p_lowmax; lo_q <= 10 * BIT_DIV; endproperty
  a_lowmax: assert property (p_lowmax) else $error("low run long");
  property p_end; !txd |-> ##[0:40] txd; endproperty
  a_end: assert property (p_end) else $error("line stuck low");
  property p_idle; $rose(ARST_N) |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("line not idle");
endmodule

//--- bench/tb_uart_tx_double_buffer.sv
// Self-checking bench for the double-buffered serial transmitter
`timescale 1ns/1ns
module tb_uart_tx_double_buffer;
  import utxdb_pkg::*;
  // ****************************************
  // Bench, model queue and checks
  // ****************************************
  localparam int DIV = 4;
  logic        CLK, ARST_N, cyc, stb, we, ack, irq, rv, rb9, rfe, nine, dbe;
  logic [3:0]  adr;
  logic [7:0]  rd;
  logic [8:0]  e9;
  logic [31:0] dat, rdat, r;
  logic [8:0]  expq[$];
  int          num_errors, num_checks, cyc_n, last_v, fb;
  utxdb_if line();
  utxdb_tx #(.BIT_DIV(DIV)) i_utxdb_tx (.CLK(CLK), .ARST_N(ARST_N),
    .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hF),
    .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK(ack), .IRQ(irq), .LINE(line));
  utxdb_rx #(.BIT_DIV(DIV)) i_utxdb_rx (.CLK(CLK), .ARST_N(ARST_N),
    .NINE_BITS(nine), .RX_DATA(rd), .RX_BIT9(rb9), .RX_VALID(rv),
    .RX_FRAME_ERR(rfe), .LINE(line));
  utxdb_monitor #(.BIT_DIV(DIV)) i_utxdb_monitor (.CLK(CLK),
    .ARST_N(ARST_N), .txd(line.txd));
  task automatic chk(input string s, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", s, e, g);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge CLK);
    while (ack !== 1'b1 && n++ < 20) @(posedge CLK);
    if (ack !== 1'b1) num_errors++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Unbuffered runs poll busy so the ninth bit never moves mid-frame
  task automatic run(input int m, input bit b);
    logic [8:0] v;
    wb(1'b1, ADDR_MASK, {7'h0, b});
    nine <= m >= 2;
    dbe = b;
    fb = m >= 2 ? BITS_MODE23 : BITS_MODE1;
    last_v = -1;
    repeat (4) begin
      v = 9'($urandom);
      do wb(1'b0, ADDR_STATUS, 8'h00);
      while (r[b ? ST_FULL_BIT : ST_BUSY_BIT] !== 1'b0);
      wb(1'b1, ADDR_CTRL, {b, 4'h0, v[8], 2'(m)});
      wb(1'b1, ADDR_DATA, v[7:0]);
      expq.push_back(v);
    end
    while (expq.size() != 0) @(posedge CLK);
    repeat (DIV) @(posedge CLK);
    chk("irq", {31'h0, b}, {31'h0, irq});
    wb(1'b0, ADDR_STATUS, 8'h00);
    chk("status", 32'h1, r);
  endtask
  always @(posedge CLK) begin
    cyc_n++;
    if (rv === 1'b1) begin
      e9 = expq.pop_front();
      chk("rx data", {24'h0, e9[7:0]}, {24'h0, rd});
      if (nine) chk("rx bit9", {31'h0, e9[8]}, {31'h0, rb9});
      chk("frame err", 32'h0, {31'h0, rfe});
      if (dbe && last_v >= 0) chk("gap", fb * DIV, cyc_n - last_v);
      last_v = cyc_n;
    end
  end
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  initial begin
    #1000000;
    num_errors++;
    end_of_test();
  end
  initial begin
    {ARST_N, cyc, stb, we, nine, dbe} = 6'h00;
    adr = 4'h0;
    dat = 32'h0;
    void'($urandom(32'hB4855C94));
    repeat (3) @(posedge CLK);
    ARST_N <= 1'b1;
    wb(1'b0, ADDR_CTRL, 8'h00);
    chk("ctrl reset", {24'h0, CTRL_RESET}, r);
    wb(1'b0, ADDR_MASK, 8'h00);
    chk("mask reset", {24'h0, MASK_RESET}, r);
    wb(1'b0, ADDR_DATA, 8'h00);
    chk("data read", 32'h0, r);
    wb(1'b0, 4'h1, 8'h00);
    chk("unmapped", 32'h0, r);
    for (int m = 0; m < 4; m++) begin
      run(m, 1'b0);
      if (m != 0) run(m, 1'b1);
    end
    end_of_test();
  end
endmodule
